// ==== dyn_threshold_ctrl.v ====
// Dynamic threshold control register bank with its APB slave.
// Assumes temperatures and core reading come from the monitor on clk.
// How it works
// - Bit 0 is Remote 2 interval code MSB
// - Interval code sets cycles between adjustments
// - Guarded core-low on standby sets status bit 1
// - Core-low raises alert when enabled
// - Core-low stops processor-hot monitoring
// - Core-low suspends dynamic control, blocks shutdown
// - Core recovery restores suspended functions
// - Bit 2 captures Remote 1 on alarm
// - Bit 2 clear keeps Remote 1 point
// - Bit 3 captures local on alarm
// - Bit 3 clear keeps local point
// - Bit 4 captures Remote 2 on alarm
// - Bit 4 clear keeps Remote 2 point
// - Bits 5-7 enable per-channel dynamic control
// - Adjust threshold from temperature, point, limits
// - Disabled channel threshold stays untouched
// - Register resets to zero
// - Lock bit makes control and operating-point registers read-only to the bus
`timescale 1ns/1ns
`include "dyn_threshold_defs.vh"
module dyn_threshold_ctrl #(
   parameter CLK_PER_CYCLE = `DIV_DEFAULT,
   parameter [7:0] HIGH_MARGIN = 8'h05,
   parameter [7:0] LOW_MARGIN = 8'h05
) (
   input wire clk,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire thermal_alarm_pin_n,
   input wire processor_hot_input,
   input wire [7:0] core_voltage_input,
   input wire [7:0] temp_r1,
   input wire [7:0] temp_loc,
   input wire [7:0] temp_r2,
   input wire alert_en,
   input wire shutdown_req,
   output reg smbalert_n,
   output reg proc_hot_seen,
   output reg shutdown,
   output reg [2:0] dyn_active
);
   reg [7:0] ctrl1_r;
   reg [7:0] ctrl2_r;
   reg [7:0] oppt_r [0:2];
   reg [7:0] tmin_r [0:2];
   reg [7:0] core_limit_r;
   reg [1:0] cfg_r;
   reg [7:0] status_r;
   reg [31:0] div_r;
   reg tick_r;
   reg [7:0] core_r;
   reg core_low_r;
   reg hot_s1_r;
   reg hot_s2_r;
   reg [7:0] rd_nxt;
   reg err_nxt;
   wire alarm_rise;
   wire wr_en;
   wire guard_hit;
   wire [7:0] temp [0:2];
   wire [2:0] due;
   wire [2:0] code [0:2];
   genvar g;

   assign temp[0] = temp_r1;
   assign temp[1] = temp_loc;
   assign temp[2] = temp_r2;
   assign code[0] = ctrl2_r[2:0];
   assign code[1] = ctrl2_r[5:3];
   assign code[2] = {ctrl1_r[`BIT_R2_MSB], ctrl2_r[7:6]};
   // Writes land at the edge where the master samples pready high
   assign wr_en = psel & penable & pwrite & pready;
   assign guard_hit = ctrl1_r[`BIT_GUARD] & cfg_r[`BIT_STANDBY] & core_low_r;

   // Returns 1 when an offset names a register that the lock protects
   function is_lockable;
      input [11:0] a;
      begin
         is_lockable = (a == `OFF_CTRL1) || (a == `OFF_CTRL2) || (a == `OFF_OPPT_R1) ||
            (a == `OFF_OPPT_LOC) || (a == `OFF_OPPT_R2);
      end
   endfunction

   alarm_sync u_alarm (
      .clk(clk),
      .reset(reset),
      .din(~thermal_alarm_pin_n),
      .level(),
      .rise(alarm_rise)
   );

   // Monitoring cycle tick from the system clock
   always @(posedge clk) begin
      if (reset) begin
         div_r <= 32'h0;
         tick_r <= 1'b0;
      end else if (div_r >= CLK_PER_CYCLE - 1) begin
         div_r <= 32'h0;
         tick_r <= 1'b1;
      end else begin
         div_r <= div_r + 32'h1;
         tick_r <= 1'b0;
      end
   end

   // Core reading is registered once on clk; processor-hot input is resampled through two flops
   always @(posedge clk) begin
      if (reset) begin
         core_r <= 8'h00;
         core_low_r <= 1'b0;
         hot_s1_r <= 1'b0;
         hot_s2_r <= 1'b0;
      end else begin
         core_r <= core_voltage_input;
         core_low_r <= core_r < core_limit_r;
         hot_s1_r <= processor_hot_input;
         hot_s2_r <= hot_s1_r;
      end
   end

   // Control registers; bus writes and core-low status capture
   always @(posedge clk) begin
      if (reset) begin
         ctrl1_r <= `CTRL1_RESET;
         ctrl2_r <= `CTRL2_RESET;
         core_limit_r <= `CORE_LIMIT_RESET;
         cfg_r <= 2'b00;
         status_r <= 8'h00;
      end else begin
         if (wr_en && !(cfg_r[`BIT_LOCK] && is_lockable(paddr))) begin
            case (paddr)
               `OFF_CTRL1: ctrl1_r <= pwdata[7:0];
               `OFF_CTRL2: ctrl2_r <= pwdata[7:0];
               `OFF_CORE_LIMIT: core_limit_r <= pwdata[7:0];
               `OFF_CFG: cfg_r <= cfg_r | pwdata[1:0];
               default: ;
            endcase
         end
         // Write one to clear, but a live condition keeps the bit set
         if (wr_en && paddr == `OFF_STATUS)
            status_r <= status_r & ~pwdata[7:0];
         if (guard_hit)
            status_r[`STAT_CORE_LOW] <= 1'b1;
         if (wr_en && paddr == `OFF_CFG && !pwdata[`BIT_STANDBY])
            cfg_r[`BIT_STANDBY] <= 1'b0;
      end
   end

   generate
      for (g = 0; g < 3; g = g + 1) begin : chan
         wire run;
         wire [7:0] hi;
         wire [7:0] lo;
         localparam [31:0] OPPT_ADDR = `OFF_OPPT_R1 + 32'h4 * g;
         localparam [31:0] TMIN_ADDR = `OFF_TMIN_R1 + 32'h4 * g;
         assign run = ctrl1_r[`BIT_EN_BASE + g] & ~guard_hit;
         assign hi = oppt_r[g] + HIGH_MARGIN;
         assign lo = oppt_r[g] - LOW_MARGIN;
         cycle_timer u_timer (
            .clk(clk),
            .reset(reset),
            .tick(tick_r),
            .run(run),
            .code(code[g]),
            .rising(temp[g] < lo),
            .due(due[g])
         );
         always @(posedge clk) begin
            if (reset) begin
               oppt_r[g] <= `OPPT_RESET;
               tmin_r[g] <= `TMIN_RESET;
            end else begin
               if (alarm_rise && ctrl1_r[`BIT_CAP_BASE + g]) begin
                  oppt_r[g] <= temp[g];
               end else if (wr_en && !cfg_r[`BIT_LOCK] &&
                  paddr == OPPT_ADDR[11:0]) begin
                  oppt_r[g] <= pwdata[7:0];
               end
               if (wr_en && paddr == TMIN_ADDR[11:0]) begin
                  tmin_r[g] <= pwdata[7:0];
               end else if (run && due[g]) begin
                  // Above the point plus HIGH_MARGIN pull the start lower, below the point less LOW_MARGIN raise it
                  if (temp[g] > hi && tmin_r[g] != 8'h00)
                     tmin_r[g] <= tmin_r[g] - 8'h01;
                  else if (temp[g] < lo && tmin_r[g] != 8'hff)
                     tmin_r[g] <= tmin_r[g] + 8'h01;
               end
            end
         end
      end
   endgenerate

   // Read mux
   always @* begin
      rd_nxt = 8'h00;
      err_nxt = 1'b0;
      case (paddr)
         `OFF_CTRL1: rd_nxt = ctrl1_r;
         `OFF_CTRL2: rd_nxt = ctrl2_r;
         `OFF_OPPT_R1: rd_nxt = oppt_r[0];
         `OFF_OPPT_LOC: rd_nxt = oppt_r[1];
         `OFF_OPPT_R2: rd_nxt = oppt_r[2];
         `OFF_CFG: rd_nxt = {6'h00, cfg_r};
         `OFF_STATUS: rd_nxt = status_r;
         `OFF_TEMP_R1: rd_nxt = temp_r1;
         `OFF_TEMP_LOC: rd_nxt = temp_loc;
         `OFF_TEMP_R2: rd_nxt = temp_r2;
         `OFF_TMIN_R1: rd_nxt = tmin_r[0];
         `OFF_TMIN_LOC: rd_nxt = tmin_r[1];
         `OFF_TMIN_R2: rd_nxt = tmin_r[2];
         `OFF_CORE_LIMIT: rd_nxt = core_limit_r;
         default: err_nxt = 1'b1;
      endcase
   end

   // One wait state: pready rises the cycle after the access phase starts
   always @(posedge clk) begin
      if (reset) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= err_nxt;
         prdata <= pwrite ? 32'h0 : {24'h0, rd_nxt};
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Side effects of the core-low guard
   always @(posedge clk) begin
      if (reset) begin
         smbalert_n <= 1'b1;
         proc_hot_seen <= 1'b0;
         shutdown <= 1'b0;
         dyn_active <= 3'b000;
      end else begin
         smbalert_n <= ~(status_r[`STAT_CORE_LOW] & alert_en);
         proc_hot_seen <= hot_s2_r & ~guard_hit;
         shutdown <= shutdown_req & ~guard_hit;
         dyn_active <= ctrl1_r[7:5] & {3{~guard_hit}};
      end
   end
endmodule // dyn_threshold_ctrl

// ==== dyn_threshold_defs.vh ====
// Constants for the dynamic threshold control block.
// Assumes it is included once per file by its bare name.
`ifndef DYN_THRESHOLD_DEFS_VH
`define DYN_THRESHOLD_DEFS_VH
`define OFF_CTRL1 12'h000
`define OFF_CTRL2 12'h004
`define OFF_OPPT_R1 12'h008
`define OFF_OPPT_LOC 12'h00c
`define OFF_OPPT_R2 12'h010
`define OFF_CFG 12'h014
`define OFF_STATUS 12'h018
`define OFF_TEMP_R1 12'h01c
`define OFF_TEMP_LOC 12'h020
`define OFF_TEMP_R2 12'h024
`define OFF_TMIN_R1 12'h028
`define OFF_TMIN_LOC 12'h02c
`define OFF_TMIN_R2 12'h030
`define OFF_CORE_LIMIT 12'h034
`define CTRL1_RESET 8'h00
`define CTRL2_RESET 8'h00
`define OPPT_RESET 8'h64
`define TMIN_RESET 8'h5a
`define CORE_LIMIT_RESET 8'h00
`define BIT_R2_MSB 0
`define BIT_GUARD 1
`define BIT_CAP_BASE 2
`define BIT_EN_BASE 5
`define BIT_LOCK 0
`define BIT_STANDBY 1
`define STAT_CORE_LOW 1
`define BASE_DEC_CYCLES 12'h008
`define DIV_DEFAULT 32'h017d7840
`endif

// ==== cycle_timer.v ====
// Per-channel adjustment timer counting monitoring cycles.
// Assumes a one-cycle tick per monitoring cycle on the same clock.
`timescale 1ns/1ns
`include "dyn_threshold_defs.vh"
module cycle_timer #(
   parameter W = 12
) (
   input wire clk,
   input wire reset,
   input wire tick,
   input wire run,
   input wire [2:0] code,
   input wire rising,
   output reg due
);
   reg [W-1:0] cnt_r;
   wire [W-1:0] limit;
   // Raising the threshold waits twice as long as lowering it
   assign limit = (`BASE_DEC_CYCLES << code) << rising;
   always @(posedge clk) begin
      if (reset || !run) begin
         cnt_r <= {W{1'b0}};
         due <= 1'b0;
      end else begin
         due <= 1'b0;
         if (tick) begin
            if (cnt_r + 1'b1 >= limit) begin
               cnt_r <= {W{1'b0}};
               due <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end
endmodule // cycle_timer

// ==== alarm_sync.v ====
// Two-stage synchroniser with rising-edge detect.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
module alarm_sync (
   input wire clk,
   input wire reset,
   input wire din,
   output reg level,
   output reg rise
);
   reg s1_r;
   reg last_r;
   // Edge is taken from the second flop only, never from the metastable first
   always @(posedge clk) begin
      if (reset) begin
         s1_r <= 1'b0;
         level <= 1'b0;
         last_r <= 1'b0;
         rise <= 1'b0;
      end else begin
         s1_r <= din;
         level <= s1_r;
         last_r <= level;
         rise <= level & ~last_r;
      end
   end
endmodule // alarm_sync

// ==== dyn_threshold_ctrl_properties.sv ====
// Port-level checker for the dynamic threshold control bank.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
module dyn_threshold_ctrl_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic processor_hot_input,
   input wire logic alert_en,
   input wire logic shutdown_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic smbalert_n,
   input wire logic proc_hot_seen,
   input wire logic shutdown
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_answer; psel && penable && !pready |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("access not answered");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
   property p_cause; pready |-> $past(psel && penable); endproperty
   a_cause: assert property (p_cause) else $error("pready without access");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("pslverr without pready");
   property p_upper; pready |-> prdata[31:8] == 24'h000000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_alert; !smbalert_n |-> alert_en || $past(alert_en); endproperty
   a_alert: assert property (p_alert) else $error("alert while disabled");
   property p_hot; proc_hot_seen |-> $past(processor_hot_input, 2) ||
      $past(processor_hot_input, 3); endproperty
   a_hot: assert property (p_hot) else $error("processor hot without input");
   property p_shut; shutdown |-> shutdown_req || $past(shutdown_req); endproperty
   a_shut: assert property (p_shut) else $error("shutdown without request");
endmodule // dyn_threshold_ctrl_checker
bind dyn_threshold_ctrl dyn_threshold_ctrl_checker u_dyn_threshold_ctrl_checker (.clk, .reset,
   .psel, .penable, .processor_hot_input, .alert_en, .shutdown_req, .prdata, .pready,
   .pslverr, .smbalert_n, .proc_hot_seen, .shutdown);

// ==== alarm_source_model.sv ====
// Far-side model: drives the active-low thermal alarm pin.
// Assumes fire is a one-cycle request on clk.
`timescale 1ns/1ns
module alarm_source_model (
   input wire logic clk,
   input wire logic fire,
   output logic alarm_n
);
   logic [2:0] hold_r = 3'h0;
   // Held low several cycles so the two-flop synchroniser cannot miss it
   always @(posedge clk) begin
      if (fire)
         hold_r <= 3'h5;
      else if (hold_r != 3'h0)
         hold_r <= hold_r - 3'h1;
   end
   assign alarm_n = (hold_r == 3'h0);
endmodule // alarm_source_model

// ==== dyn_threshold_ctrl_tb_top.sv ====
// Self-checking testbench for the dynamic threshold control bank.
// Assumes the design, its defs header and the alarm model are compiled first.
`timescale 1ns/1ns
`include "dyn_threshold_defs.vh"
module dyn_threshold_ctrl_tb_top;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, fire = 0, alarm_n, e;
   logic processor_hot_input = 0, alert_en = 0, shutdown_req = 0;
   logic pready, pslverr, smbalert_n, proc_hot_seen, shutdown;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, q;
   logic [7:0] core_voltage_input = 8'hff, v;
   logic [7:0] t [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] p [3];
   logic [2:0] dyn_active;
   int n_errors = 0, num_checks = 0;
   dyn_threshold_ctrl #(.CLK_PER_CYCLE(4)) u_dyn_threshold_ctrl (.clk, .reset, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .thermal_alarm_pin_n(alarm_n), .processor_hot_input, .core_voltage_input,
      .temp_r1(t[0]), .temp_loc(t[1]), .temp_r2(t[2]), .alert_en, .shutdown_req,
      .smbalert_n, .proc_hot_seen, .shutdown, .dyn_active);
   alarm_source_model u_alarm_source_model (.clk, .fire, .alarm_n);
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic report_and_stop;
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Threshold after a number of monitoring ticks spent below the band
   function automatic logic [7:0] grown(input logic [7:0] b, input int ticks, input int code);
      return b + 8'(ticks / (16 << code));
   endfunction
   // Request held until pready is sampled high; only the watchdog ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
      apb(0, a, 8'h00);
      chk(nm, q, {24'h000000, exp});
   endtask
   initial begin
      void'($urandom(32'hbdd38bc6));
      repeat (2) @(posedge clk);
      reset <= 0;
      rd(`OFF_CTRL1, 8'h00, "ctrl1 reset");
      apb(1, `OFF_CTRL1, 8'h20);
      repeat (300) @(posedge clk);
      apb(0, `OFF_TMIN_R1, 8'h00);
      chk("tmin_r1", q, {24'h000000, grown(`TMIN_RESET, 75, 0)});
      rd(`OFF_TMIN_LOC, 8'h5a, "tmin_loc");
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'hff : 8'($urandom);
         apb(1, `OFF_CTRL1, v);
         repeat (2) @(posedge clk);
         chk("dyn_active", dyn_active, v[7:5]);
         rd(`OFF_CTRL1, v, "ctrl1");
      end
      for (int i = 0; i < 3; i++) begin
         p[i] = 8'($urandom);
         t[i] <= ~p[i];
         apb(1, 12'(`OFF_OPPT_R1 + 4 * i), p[i]);
      end
      apb(1, `OFF_CTRL1, 8'h14);
      fire <= 1;
      @(posedge clk);
      fire <= 0;
      repeat (10) @(posedge clk);
      for (int i = 0; i < 3; i++)
         rd(12'(`OFF_OPPT_R1 + 4 * i), i == 1 ? p[i] : t[i], "oppt");
      apb(1, `OFF_CORE_LIMIT, 8'h80);
      apb(1, `OFF_CFG, 8'h02);
      apb(1, `OFF_CTRL1, 8'he2);
      alert_en <= 1;
      processor_hot_input <= 1;
      shutdown_req <= 1;
      core_voltage_input <= 8'h7f;
      repeat (6) @(posedge clk);
      rd(`OFF_STATUS, 8'h02, "status");
      chk("smbalert_n", smbalert_n, 0);
      chk("proc_hot_seen", proc_hot_seen, 0);
      chk("guarded", {shutdown, dyn_active}, 0);
      core_voltage_input <= 8'h81;
      repeat (6) @(posedge clk);
      chk("restored", {proc_hot_seen, shutdown, dyn_active}, 5'h1f);
      apb(0, 12'h0fc, 8'h00);
      chk("unmapped", e, 1);
      apb(1, `OFF_CFG, 8'h03);
      apb(1, `OFF_CTRL1, 8'h00);
      rd(`OFF_CTRL1, 8'he2, "locked");
      reset <= 1;
      repeat (2) @(posedge clk);
      reset <= 0;
      rd(`OFF_CTRL1, `CTRL1_RESET, "ctrl1 after reset");
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      report_and_stop;
   end
endmodule // dyn_threshold_ctrl_tb_top
